/* logic/vrs_pkg.sv */
`default_nettype none
package vrs_pkg;
	// Register word indices; the byte address is four times the index.
	localparam logic [5:0] LEVEL_SELECT_IDX = 6'h00;
	localparam logic [5:0] FORCE_ON_IDX = 6'h01;
	localparam logic [7:0] LEVEL_SELECT_RESET = 8'h00;
	localparam logic [7:0] FORCE_ON_RESET = 8'h00;
	localparam logic [7:0] LEVEL_SELECT_MASK = 8'h77;
	localparam logic [7:0] FORCE_ON_MASK = 8'h03;
	localparam int SEL_W = 3;
	localparam int CONVERTER_SEL_LSB = 4;
	localparam int SHARED_SEL_LSB = 0;
	localparam int CONVERTER_FORCE_BIT = 1;
	localparam int SHARED_FORCE_BIT = 0;
	localparam logic [2:0] LEVEL_0V55 = 3'h0;
	localparam logic [2:0] LEVEL_1V1 = 3'h1;
	localparam logic [2:0] LEVEL_2V5 = 3'h2;
	localparam logic [2:0] LEVEL_4V3 = 3'h3;
	localparam logic [2:0] LEVEL_1V5 = 3'h4;
endpackage
`default_nettype wire

/* logic/vrs_source_enable.sv */
`timescale 1ns/1ns
`default_nettype none
module vrs_source_enable #(
	parameter int N_REQ = 1
) (
	input wire logic [N_REQ-1:0] req_i,
	input wire logic force_i,
	output logic en_o
);
	// The source runs while any consumer asks for it or software forces it.
	assign en_o = (|req_i) | force_i;
endmodule
`default_nettype wire

/* logic/vrs_top.sv */
// Summary of operation
// - Converter level code in bits six to four.
// - Shared level code in bits two to zero.
// - Requests switch a source on automatically.
// - Unrequested source off unless forced on.
// - Shared by comparator or DAC; converter by ADC.
// - Second register bit one forces converter source.
// - Second register bit zero forces shared source.
// - Both level fields reset to code zero.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module vrs_top #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic adc_req_i,
	input wire logic dac_req_i,
	input wire logic ac_req_i,
	output logic [vrs_pkg::SEL_W-1:0] converter_level_o,
	output logic [vrs_pkg::SEL_W-1:0] shared_level_o,
	output logic converter_source_en_o,
	output logic shared_source_en_o
);
	import vrs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic [7:0] level_reg;
	logic [7:0] level_next;
	logic [7:0] force_reg;
	logic [7:0] force_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;

	// True when the address is the aligned word of the given index.
	function automatic logic hits(input logic [ADDR_W-1:0] adr,
		input logic [5:0] idx);
		hits = (adr[1:0] == 2'h0) && (adr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
	endfunction

	wire logic access_now;
	wire logic write_now;
	wire logic level_hit;
	wire logic force_hit;
	wire logic lane0_write;

	assign access_now = wb_cyc_i && wb_stb_i && !ack_reg;
	assign write_now = access_now && wb_we_i;
	assign level_hit = hits(wb_adr_i, LEVEL_SELECT_IDX);
	assign force_hit = hits(wb_adr_i, FORCE_ON_IDX);
	assign lane0_write = write_now && wb_sel_i[0];

	////////////////////////////////////////////////////////////////////////
	// Register next values.

	// Unmapped addresses are acknowledged, read zero and drop writes.
	assign level_next = (lane0_write && level_hit) ?
		(wb_dat_i[7:0] & LEVEL_SELECT_MASK) : level_reg;
	assign force_next = (lane0_write && force_hit) ?
		(wb_dat_i[7:0] & FORCE_ON_MASK) : force_reg;
	assign ack_next = access_now;
	assign dat_next = !(access_now && !wb_we_i) ? 32'h0000_0000 :
		level_hit ? {24'h00_0000, level_reg} :
		force_hit ? {24'h00_0000, force_reg} :
		32'h0000_0000;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			level_reg <= LEVEL_SELECT_RESET;
			force_reg <= FORCE_ON_RESET;
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end
		else
		begin
			level_reg <= level_next;
			force_reg <= force_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	////////////////////////////////////////////////////////////////////////
	// Reference source control.

	// Reserved codes pass through to the source exactly as stored.
	assign converter_level_o =
		level_reg[CONVERTER_SEL_LSB +: SEL_W];
	assign shared_level_o = level_reg[SHARED_SEL_LSB +: SEL_W];

	// The enables stay combinational so a request is served at once.
	vrs_source_enable #(
		.N_REQ(1)
	) u_converter_enable (
		.req_i(adc_req_i),
		.force_i(force_reg[CONVERTER_FORCE_BIT]),
		.en_o(converter_source_en_o)
	);

	vrs_source_enable #(
		.N_REQ(2)
	) u_shared_enable (
		.req_i({ac_req_i, dac_req_i}),
		.force_i(force_reg[SHARED_FORCE_BIT]),
		.en_o(shared_source_en_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_converter_on_req: assert property (
		@(posedge clk_i) disable iff (rst_i)
		adc_req_i |-> converter_source_en_o)
		else $error("converter source off while requested");

	a_shared_on_req: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(dac_req_i || ac_req_i) |-> shared_source_en_o)
		else $error("shared source off while requested");

	a_converter_auto_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!adc_req_i && !force_reg[CONVERTER_FORCE_BIT])
		|-> !converter_source_en_o)
		else $error("converter source on with no cause");

	a_shared_auto_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!dac_req_i && !ac_req_i && !force_reg[SHARED_FORCE_BIT])
		|-> !shared_source_en_o)
		else $error("shared source on with no cause");

	a_converter_force_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(lane0_write && force_hit && wb_dat_i[CONVERTER_FORCE_BIT])
		|=> converter_source_en_o [*3])
		else $error("converter force did not hold source on");

	a_shared_force_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(lane0_write && force_hit && wb_dat_i[SHARED_FORCE_BIT])
		|=> shared_source_en_o)
		else $error("shared force did not hold source on");

	a_reset_levels: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> (converter_level_o == LEVEL_0V55 &&
		shared_level_o == LEVEL_0V55 && !wb_ack_o))
		else $error("level fields not zero after reset");

	a_level_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(lane0_write && level_hit) |=>
		(converter_level_o == $past(wb_dat_i[6:4]) &&
		shared_level_o == $past(wb_dat_i[2:0]) && wb_ack_o))
		else $error("level write not stored");

	a_unused_zero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> (wb_dat_o[31:8] == 24'h00_0000 &&
		level_reg[7] == 1'b0 && level_reg[3] == 1'b0 &&
		force_reg[7:2] == 6'h00))
		else $error("unused bits not zero");

	a_ack_once: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");

	a_force_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(lane0_write && force_hit) |=>
		(force_reg == ($past(wb_dat_i[7:0]) & FORCE_ON_MASK)))
		else $error("force write not stored");

	a_read_level: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(access_now && !wb_we_i && level_hit) |=>
		(wb_dat_o == {24'h00_0000, $past(level_reg)}))
		else $error("level read data wrong");

	a_read_force: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(access_now && !wb_we_i && force_hit) |=>
		(wb_dat_o == {24'h00_0000, $past(force_reg)}))
		else $error("force read data wrong");

	a_unmapped_read: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(access_now && !wb_we_i && !level_hit && !force_hit) |=>
		(wb_dat_o == 32'h0000_0000))
		else $error("unmapped read not zero");

	a_write_ignored: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(write_now && (!wb_sel_i[0] || (!level_hit && !force_hit))) |=>
		($stable(level_reg) && $stable(force_reg)))
		else $error("ignored write changed a register");

	a_data_idle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
		else $error("read data not zero outside ack");
endmodule
`default_nettype wire

/* tb/vrs_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
module vrs_periph_model (
	input wire logic clk_i,
	input wire logic [2:0] want_i,
	output logic adc_req_o,
	output logic dac_req_o,
	output logic ac_req_o
);
	// Consumers raise their requests from their own clocked logic.
	always_ff @(posedge clk_i)
	begin
		adc_req_o <= want_i[2];
		dac_req_o <= want_i[1];
		ac_req_o <= want_i[0];
	end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk_i, rst_i, cyc, we, ce, se;
	logic [7:0] adr, q, a;
	logic [31:0] dat, rdat, r;
	logic ack, ar, dr, cr;
	logic [2:0] want, cl, sl;
	logic [3:0] sel, lanes;
	int err_total, num_checks, ticks;
	vrs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .adc_req_i(ar),
		.dac_req_i(dr), .ac_req_i(cr), .converter_level_o(cl),
		.shared_level_o(sl), .converter_source_en_o(ce),
		.shared_source_en_o(se));
	vrs_periph_model pm (.clk_i(clk_i), .want_i(want), .adc_req_o(ar),
		.dac_req_o(dr), .ac_req_o(cr));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction
	function automatic logic [7:0] en(input logic [2:0] w, input logic [7:0] f);
		en = {6'h0, w[2] | f[1], w[1] | w[0] | f[0]};
	endfunction
	task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		sel <= lanes;
		adr <= ad;
		dat <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		q = rdat[7:0];
		cyc <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		ticks <= ticks + 1;
		if (ticks == 3000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	initial
	begin
		rst_i = 1'b1;
		cyc = 1'b0;
		we = 1'b0;
		sel = 4'h1;
		lanes = 4'h1;
		adr = 8'h00;
		dat = 32'h0;
		want = 3'h0;
		r = 32'he26f782f;
		err_total = 0;
		num_checks = 0;
		ticks = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 8'h00);
		chk(q, 8'h00);
		chk({1'b0, cl, 1'b0, sl}, 8'h00);
		wb(1'b0, 8'h04, 8'h00);
		chk(q, 8'h00);
		for (int i = 0; i < 24; i++)
		begin
			r = xs(r);
			a = (i < 5) ? {2{1'b0, i[2:0]}} : (i == 5) ? 8'hff : r[7:0];
			wb(1'b1, 8'h00, a);
			wb(1'b1, 8'h04, r[15:8]);
			wb(1'b0, 8'h00, 8'h00);
			chk(q, a & 8'h77);
			chk({1'b0, cl, 1'b0, sl}, a & 8'h77);
			wb(1'b0, 8'h04, 8'h00);
			chk(q, r[15:8] & 8'h03);
			want <= r[18:16];
			repeat (2) @(posedge clk_i);
			chk({6'h0, ce, se}, en(r[18:16], r[15:8]));
		end
		wb(1'b1, 8'h08, 8'h5a);
		wb(1'b0, 8'h08, 8'h00);
		chk(q, 8'h00);
		wb(1'b1, 8'h00, 8'h43);
		wb(1'b1, 8'h04, 8'h03);
		chk({6'h0, ce, se}, en(want, 8'h03));
		lanes = 4'h0;
		wb(1'b1, 8'h00, 8'h25);
		lanes = 4'h1;
		wb(1'b1, 8'h01, 8'h12);
		wb(1'b0, 8'h01, 8'h00);
		chk(q, 8'h00);
		wb(1'b0, 8'h00, 8'h00);
		chk(q, 8'h43);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 8'h00);
		chk(q, 8'h00);
		chk({1'b0, cl, 1'b0, sl}, 8'h00);
		wb(1'b0, 8'h04, 8'h00);
		chk(q, 8'h00);
		chk({6'h0, ce, se}, en(want, 8'h00));
		report_and_stop();
	end
endmodule
`default_nettype wire
